// [rtl/tcb_pkg.sv]
// shared constants and types for the tape command register bank
package tcb_pkg;

  // register indices on the documented register port
  localparam logic [0:0]  REG_IDX_CMD       = 1'h0;
  localparam logic [0:0]  REG_IDX_BRC       = 1'h1;

  // command register field positions
  localparam int          CMD_GO_BIT        = 0;
  localparam int          CMD_FCN_LSB       = 1;
  localparam int          CMD_EXT_LSB       = 4;
  localparam int          CMD_IE_BIT        = 6;
  localparam int          CMD_RDY_BIT       = 7;

  // reset values
  localparam logic [15:0] BRC_RESET         = 16'h0000;
  localparam logic [1:0]  EXT_RESET         = 2'h0;

  // go pulse timing: 1 us least, at an 8 ns clock
  localparam int          CLK_PERIOD_NS     = 8;
  localparam int          GO_PULSE_NS       = 1000;
  localparam int          GO_PULSE_CYC      = (GO_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0]  GO_PULSE_LAST     = 8'(GO_PULSE_CYC - 1);

  // function codes of bits 3..1
  typedef enum logic [2:0] {
    TCB_FN_OFFLINE  = 3'h0,
    TCB_FN_READ     = 3'h1,
    TCB_FN_WRITE    = 3'h2,
    TCB_FN_WEOF     = 3'h3,
    TCB_FN_SPC_FWD  = 3'h4,
    TCB_FN_SPC_REV  = 3'h5,
    TCB_FN_WR_GAP   = 3'h6,
    TCB_FN_REWIND   = 3'h7
  } tcb_fn_t;

  // sequencer states
  typedef enum logic [1:0] {
    TCB_IDLE,
    TCB_WAIT_UNIT,
    TCB_PULSE,
    TCB_BUSY
  } tcb_state_t;

  // register port write request
  typedef struct packed {
    logic        wr;
    logic [0:0]  idx;
    logic [15:0] data;
  } tcb_wr_t;

  // transport pin inputs, before synchronisation
  typedef struct packed {
    logic        unit_rewinding;
    logic        op_done;
    logic        rewind_done;
    logic        lrc_strobe;
  } tcb_pins_t;

  // all state of the command bank except the byte/record counter
  typedef struct packed {
    tcb_state_t  state;
    logic        go;
    logic        ready;
    logic        ie;
    logic [1:0]  ext;
    tcb_fn_t     fcn;
    logic        irq;
    logic        go_pulse;
    logic [7:0]  pulse_cnt;
    logic        fault_prev;
    logic        rewinding;
    tcb_pins_t   sync1;
    tcb_pins_t   sync2;
    tcb_pins_t   pins_prev;
    logic [15:0] cmd_rd;
  } tcb_regs_t;

endpackage

// [rtl/tcb_counter.sv]
// byte/record counter: software load, initialize clear, increment by one
`timescale 1ns/1ps
module tcb_counter #(
  parameter int WIDTH = 16
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             clear,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_data,
  input  wire logic             inc,
  output logic      [WIDTH-1:0] count
);

  logic [WIDTH-1:0] count_r;   // counter value
  logic [WIDTH-1:0] count_nxt; // next counter value

  // clear beats load, load beats increment
  always_comb begin
    count_nxt = count_r;
    if (clear) begin
      count_nxt = '0;
    end else if (load) begin
      count_nxt = load_data;
    end else if (inc) begin
      count_nxt = count_r + WIDTH'(1);
    end
  end

  // counter register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

  assign count = count_r;

endmodule

// [rtl/tcb_cmd_bank.sv]
// tape controller command register low byte and byte/record counter
//
// Summary of operation
// - ready clears at operation start, sets at end
// - ready also sets on fault and initialize
// - enabled interrupt on ready or fault flag
// - rewind interrupts at start and at completion
// - enable write without go requests interrupt
// - extended address bits drive lines 17..16
// - extended bits take address register carry
// - bits 3..1 pick function, initialize clears
// - software writes go, controller starts operation
// - go holds until go pulse is sent
// - go clears on initialize and fault
// - counter clears on initialize, counts accesses
// - spacing counts once per record check character
`timescale 1ns/1ps
module tcb_cmd_bank
  import tcb_pkg::*;
#(
  parameter int BRC_WIDTH = 16
) (
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire logic                 bus_init,
  input  wire tcb_wr_t              reg_wr,
  output logic      [15:0]          cmd_rd_data,
  output logic      [BRC_WIDTH-1:0] brc_rd_data,
  input  wire logic                 status_fault_flag,
  input  wire logic                 mem_access,
  input  wire logic                 current_memory_address_carry,
  input  wire tcb_pins_t            pins,
  output logic                      go_pulse,
  output logic      [2:0]           function_code,
  output logic      [1:0]           extended_address,
  output logic                      irq,
  input  wire logic                 irq_ack
);

  tcb_regs_t r_r;   // registered state
  tcb_regs_t r_nxt; // next state

  logic      cmd_wr;      // write to the command register
  logic      fault_rise;  // status fault flag just became set
  logic      op_done_ev;  // synchronised end-of-operation edge
  logic      rew_done_ev; // synchronised rewind completion edge
  logic      lrc_ev;      // synchronised check character edge
  logic      spacing;     // a space operation is running
  logic      brc_inc;     // counter increment request
  logic      brc_load;    // counter load from software

  // decode and edge detection on the synchronised pins and the status fault flag
  always_comb begin
    cmd_wr      = reg_wr.wr && (reg_wr.idx == REG_IDX_CMD);
    brc_load    = reg_wr.wr && (reg_wr.idx == REG_IDX_BRC);
    fault_rise  = status_fault_flag && !r_r.fault_prev;
    op_done_ev  = r_r.sync2.op_done && !r_r.pins_prev.op_done;
    rew_done_ev = r_r.sync2.rewind_done && !r_r.pins_prev.rewind_done;
    lrc_ev      = r_r.sync2.lrc_strobe && !r_r.pins_prev.lrc_strobe;
    spacing     = (r_r.state == TCB_BUSY) &&
                  ((r_r.fcn == TCB_FN_SPC_FWD) || (r_r.fcn == TCB_FN_SPC_REV));
    brc_inc     = mem_access || (spacing && lrc_ev);
  end

  // next-state logic for the whole bank except the byte/record counter
  always_comb begin
    r_nxt            = r_r;
    r_nxt.sync1      = pins;
    r_nxt.sync2      = r_r.sync1;
    r_nxt.pins_prev  = r_r.sync2;
    r_nxt.fault_prev = status_fault_flag;
    r_nxt.go_pulse   = 1'b0;

    // interrupt request withdrawn on acknowledge; later sets win
    if (irq_ack) begin
      r_nxt.irq = 1'b0;
    end

    // extended address follows the address register carry
    if (mem_access && current_memory_address_carry) begin
      r_nxt.ext = r_r.ext + 2'h1;
    end

    // software write of the command byte
    if (cmd_wr) begin
      r_nxt.ie  = reg_wr.data[CMD_IE_BIT];
      r_nxt.ext = reg_wr.data[CMD_EXT_LSB +: 2];
      r_nxt.fcn = tcb_fn_t'(reg_wr.data[CMD_FCN_LSB +: 3]);
      if (reg_wr.data[CMD_IE_BIT] && !reg_wr.data[CMD_GO_BIT]) begin
        r_nxt.irq = 1'b1;
      end
      if (reg_wr.data[CMD_GO_BIT] && r_r.state == TCB_IDLE) begin
        r_nxt.go    = 1'b1;
        r_nxt.ready = 1'b0;
        r_nxt.state = TCB_WAIT_UNIT;
      end
    end

    // rewind completion on the transport
    if (rew_done_ev && r_r.rewinding) begin
      r_nxt.rewinding = 1'b0;
      if (r_r.ie) begin
        r_nxt.irq = 1'b1;
      end
    end

    // operation sequencer
    unique case (r_r.state)
      // waiting for commands
      TCB_IDLE: begin
      end
      // unit still rewinding: go stays set meanwhile
      TCB_WAIT_UNIT: begin
        if (!r_r.sync2.unit_rewinding) begin
          r_nxt.state     = TCB_PULSE;
          r_nxt.pulse_cnt = 8'h00;
          // raise the pulse with the state change, so it lasts the full count
          r_nxt.go_pulse  = 1'b1;
        end
      end
      // go pulse to the transport for its least width
      TCB_PULSE: begin
        r_nxt.go_pulse = 1'b1;
        if (r_r.pulse_cnt == GO_PULSE_LAST) begin
          r_nxt.go_pulse = 1'b0;
          r_nxt.go       = 1'b0;
          if (r_r.fcn == TCB_FN_REWIND) begin
            r_nxt.state     = TCB_IDLE;
            r_nxt.ready     = 1'b1;
            r_nxt.rewinding = 1'b1;
            if (r_r.ie) begin
              r_nxt.irq = 1'b1;
            end
          end else begin
            r_nxt.state = TCB_BUSY;
          end
        end else begin
          r_nxt.pulse_cnt = r_r.pulse_cnt + 8'h01;
        end
      end
      // transfer or tape motion in progress
      TCB_BUSY: begin
        if (op_done_ev) begin
          r_nxt.state = TCB_IDLE;
          r_nxt.ready = 1'b1;
          if (r_r.ie) begin
            r_nxt.irq = 1'b1;
          end
        end
      end
    endcase

    // fault aborts the operation and flags ready
    if (fault_rise) begin
      r_nxt.go       = 1'b0;
      r_nxt.ready    = 1'b1;
      r_nxt.go_pulse = 1'b0;
      r_nxt.state    = TCB_IDLE;
      if (r_r.ie || (cmd_wr && reg_wr.data[CMD_IE_BIT])) begin
        r_nxt.irq = 1'b1;
      end
    end

    // bus initialize clears the bank
    if (bus_init) begin
      r_nxt.state     = TCB_IDLE;
      r_nxt.go        = 1'b0;
      r_nxt.ready     = 1'b1;
      r_nxt.ie        = 1'b0;
      r_nxt.ext       = EXT_RESET;
      r_nxt.fcn       = TCB_FN_OFFLINE;
      r_nxt.irq       = 1'b0;
      r_nxt.go_pulse  = 1'b0;
      r_nxt.rewinding = 1'b0;
    end

    // read image of the command register, upper byte outside this bank
    r_nxt.cmd_rd                          = 16'h0000;
    r_nxt.cmd_rd[CMD_GO_BIT]              = r_nxt.go;
    r_nxt.cmd_rd[CMD_FCN_LSB +: 3]        = r_nxt.fcn;
    r_nxt.cmd_rd[CMD_EXT_LSB +: 2]        = r_nxt.ext;
    r_nxt.cmd_rd[CMD_IE_BIT]              = r_nxt.ie;
    r_nxt.cmd_rd[CMD_RDY_BIT]             = r_nxt.ready;
  end

  // state register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      r_r                     <= '0;
      r_r.state               <= TCB_IDLE;
      r_r.ready               <= 1'b1;
      r_r.fcn                 <= TCB_FN_OFFLINE;
      r_r.ext                 <= EXT_RESET;
      r_r.cmd_rd              <= 16'h0080;
    end else begin
      r_r <= r_nxt;
    end
  end

  // byte/record counter
  tcb_counter #(
    .WIDTH     (BRC_WIDTH)
  ) u_brc (
    .clk       (clk),
    .reset     (reset),
    .clear     (bus_init),
    .load      (brc_load),
    .load_data (reg_wr.data[BRC_WIDTH-1:0]),
    .inc       (brc_inc),
    .count     (brc_rd_data)
  );

  // outputs straight from the state register
  assign cmd_rd_data      = r_r.cmd_rd;
  assign go_pulse         = r_r.go_pulse;
  assign function_code    = r_r.fcn;
  assign extended_address = r_r.ext;
  assign irq              = r_r.irq;

endmodule

// [tb/tcb_cmd_bank_asserts.sv]
// assertion checker for the tape command register bank
`timescale 1ns/1ps
module tcb_cmd_bank_asserts
  import tcb_pkg::*;
#(
  parameter int BRC_WIDTH = 16
) (
  input wire logic                 clk,
  input wire logic                 reset,
  input wire logic                 bus_init,
  input wire tcb_wr_t              reg_wr,
  input wire logic [15:0]          cmd_rd_data,
  input wire logic [BRC_WIDTH-1:0] brc_rd_data,
  input wire logic                 status_fault_flag,
  input wire logic                 mem_access,
  input wire logic                 current_memory_address_carry,
  input wire logic                 go_pulse,
  input wire logic [2:0]           function_code,
  input wire logic [1:0]           extended_address,
  input wire logic                 irq,
  input wire logic                 irq_ack
);
  logic [7:0] run_r;  // cycles the go pulse has been high
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // measure each go pulse, restart while low
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      run_r <= 8'h00;
    end else begin
      run_r <= go_pulse ? run_r + 8'h01 : 8'h00;
    end
  end
  AST_INIT: assert property (bus_init |=> cmd_rd_data == 16'h0080 && !irq)
    else $error("initialize did not restore the command bits");
  AST_IE_IRQ: assert property (reg_wr.wr && reg_wr.idx == REG_IDX_CMD && reg_wr.data[6]
    && !reg_wr.data[0] && !bus_init |=> irq) else $error("enable write gave no request");
  AST_GO_START: assert property (reg_wr.wr && reg_wr.idx == REG_IDX_CMD
    && reg_wr.data[0] && cmd_rd_data[7] && !bus_init && !status_fault_flag
    |=> cmd_rd_data[0] && !cmd_rd_data[7]) else $error("go did not start an operation");
  AST_PULSE_LEN: assert property ($fell(go_pulse) && !$past(status_fault_flag)
    && !$past(bus_init) |-> run_r == GO_PULSE_LAST + 8'h01) else $error("go pulse length");
  AST_GO_HELD: assert property (go_pulse |-> cmd_rd_data[0])
    else $error("go bit dropped during the go pulse");
  AST_FAULT: assert property ($rose(status_fault_flag)
    |=> cmd_rd_data[7] && !cmd_rd_data[0] && !go_pulse) else $error("fault left go set");
  AST_IRQ_HOLD: assert property (irq && !irq_ack && !bus_init |=> irq)
    else $error("request withdrawn without acknowledge");
  AST_IRQ_EN: assert property ($rose(irq) |-> cmd_rd_data[6])
    else $error("request raised while disabled");
  AST_EXT_INC: assert property (mem_access && current_memory_address_carry && !reg_wr.wr
    && !bus_init |=> extended_address == $past(extended_address) + 2'h1)
    else $error("extended address missed the carry");
  AST_BRC_INC: assert property (mem_access && !reg_wr.wr && !bus_init
    |=> brc_rd_data == $past(brc_rd_data) + 1'b1) else $error("counter missed an access");
  // a command write lands on the address lines and the function code
  AST_PINS: assert property (reg_wr.wr && reg_wr.idx == REG_IDX_CMD && !bus_init
    |=> extended_address == $past(reg_wr.data[5:4])
    && function_code == $past(reg_wr.data[3:1])) else $error("outputs differ from written bits");
  // main scenarios reached
  cover property (go_pulse && function_code == TCB_FN_REWIND);
  cover property (irq && irq_ack);
  cover property ($rose(status_fault_flag) && go_pulse);
endmodule
bind tcb_cmd_bank tcb_cmd_bank_asserts #(.BRC_WIDTH(BRC_WIDTH)) u_chk (.clk(clk),
  .reset(reset), .bus_init(bus_init), .reg_wr(reg_wr), .cmd_rd_data(cmd_rd_data),
  .brc_rd_data(brc_rd_data), .status_fault_flag(status_fault_flag),
  .mem_access(mem_access), .current_memory_address_carry(current_memory_address_carry),
  .go_pulse(go_pulse), .function_code(function_code),
  .extended_address(extended_address), .irq(irq), .irq_ack(irq_ack));

// [tb/tcb_transport_model.sv]
// behavioural tape transport answering the go pulse
`timescale 1ns/1ps
module tcb_transport_model
  import tcb_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       go_pulse,
  input  wire logic [2:0] function_code,
  input  wire logic [7:0] delay,
  input  wire logic [3:0] nrec,
  output tcb_pins_t       pins
);
  logic [3:0] p = 4'h0;  // rewinding, done, rewind done, check char
  assign pins = p;
  // one transport level strobe
  task automatic strobe(input int b);
    p[b] = 1'b1;
    repeat (4) @(negedge clk);
    p[b] = 1'b0;
    // short low time, so the model is soon waiting again for the next go pulse
    repeat (2) @(negedge clk);
  endtask
  // serve each go pulse that rises while the model is waiting for one
  always begin
    @(posedge go_pulse);
    if (function_code == TCB_FN_REWIND) begin
      p[3] = 1'b1;  // unit busy from go on
      @(negedge go_pulse);
      fork
        begin
          repeat (delay) @(negedge clk);
          p[3] = 1'b0;
          strobe(1);
        end
      join_none
    end else begin
      @(negedge go_pulse);
      if (function_code[2:1] == 2'b10) begin
        repeat (nrec) strobe(0);
      end
      repeat (delay) @(negedge clk);
      strobe(2);
    end
  end
endmodule

// [tb/tcb_cmd_bank_bench.sv]
// self-checking bench for the tape command register bank
`timescale 1ns/1ps
module tcb_cmd_bank_bench;
  import tcb_pkg::*;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        bus_init = 1'b0;
  tcb_wr_t     reg_wr = '0;
  logic        fault = 1'b0;
  logic        mem_access = 1'b0;
  logic        carry = 1'b0;
  logic        irq_ack = 1'b0;
  logic [7:0]  delay = 8'h3C;
  tcb_pins_t   pins;
  logic [15:0] cmd_rd_data;
  logic [15:0] brc_rd_data;
  logic        go_pulse;
  logic [2:0]  function_code;
  logic [1:0]  extended_address;
  logic        irq;
  int          err_total = 0;
  int          checked = 0;
  always #4 clk = ~clk;
  tcb_cmd_bank dut (.clk(clk), .reset(reset), .bus_init(bus_init), .reg_wr(reg_wr),
    .cmd_rd_data(cmd_rd_data), .brc_rd_data(brc_rd_data), .status_fault_flag(fault),
    .mem_access(mem_access), .current_memory_address_carry(carry), .pins(pins),
    .go_pulse(go_pulse), .function_code(function_code),
    .extended_address(extended_address), .irq(irq), .irq_ack(irq_ack));
  tcb_transport_model u_tape (.clk(clk), .go_pulse(go_pulse), .function_code(function_code),
    .delay(delay), .nrec(4'h2), .pins(pins));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic idx, input logic [15:0] d);
    @(negedge clk) reg_wr = '{1'b1, idx, d};
    @(negedge clk) reg_wr.wr = 1'b0;
  endtask
  task automatic mem(input logic c);
    @(negedge clk) {mem_access, carry} = {1'b1, c};
    @(negedge clk) mem_access = 1'b0;
  endtask
  task automatic ack;
    @(negedge clk) irq_ack = 1'b1;
    @(negedge clk) irq_ack = 1'b0;
  endtask
  // bounded wait for a request, then acknowledge
  task automatic wirq(input logic [15:0] exp);
    for (int n = 0; n < 900 && irq !== 1'b1; n++) @(negedge clk);
    chk(16'(irq), 16'h0001);
    chk(cmd_rd_data, exp);
    ack();
  endtask
  task automatic t_fcn;
    chk(cmd_rd_data, 16'h0080);
    for (int f = 0; f < 8; f++) begin
      wr(REG_IDX_CMD, 16'h0030 | 16'(f << 1));
      chk({9'h0, extended_address, function_code, 2'h0}, 16'h0060 | 16'(f << 2));
    end
    @(negedge clk) bus_init = 1'b1;
    @(negedge clk) bus_init = 1'b0;
    chk(cmd_rd_data, 16'h0080);
  endtask
  task automatic t_irq;
    wr(REG_IDX_CMD, 16'h0040);
    chk(16'(irq), 16'h0001);
    repeat (5) @(negedge clk);
    chk(16'(irq), 16'h0001);
    ack();
    @(negedge clk);
    chk(16'(irq), 16'h0000);
    wr(REG_IDX_CMD, 16'h0010);
    wr(REG_IDX_BRC, 16'h0005);
    mem(1'b1);
    chk({extended_address, brc_rd_data[13:0]}, 16'h8006);
    // initialize must clear a loaded counter
    @(negedge clk) bus_init = 1'b1;
    @(negedge clk) bus_init = 1'b0;
    chk(brc_rd_data, 16'h0000);
  endtask
  task automatic t_read;
    int n;
    wr(REG_IDX_BRC, 16'hFFFD);
    wr(REG_IDX_CMD, 16'h0063);
    chk(cmd_rd_data, 16'h0063);
    for (n = 0; n < 9 && go_pulse !== 1'b1; n++) @(negedge clk);
    for (n = 0; n < 300 && go_pulse === 1'b1; n++) @(negedge clk);
    chk(16'(n), 16'(GO_PULSE_CYC));
    repeat (3) mem(1'b0);
    chk(brc_rd_data, 16'h0000);
    wirq(16'h00E2);
  endtask
  task automatic t_space;
    delay = 8'h08;
    for (int f = 4; f < 6; f++) begin
      wr(REG_IDX_BRC, 16'hFFFE);
      wr(REG_IDX_CMD, 16'h0061 | 16'(f << 1));
      wirq(16'h00E0 | 16'(f << 1));
      chk(brc_rd_data, 16'h0000);
    end
    delay = 8'h3C;
  endtask
  task automatic t_rewind;
    wr(REG_IDX_CMD, 16'h004F);
    wirq(16'h00CE);
    wr(REG_IDX_CMD, 16'h0043);
    repeat (20) @(negedge clk);
    chk({go_pulse, cmd_rd_data[7:0]}, 16'h0043);
    // rewind completion interrupts while the waiting go is being sent
    wirq(16'h0043);
    wirq(16'h00C2);
  endtask
  task automatic t_fault;
    wr(REG_IDX_CMD, 16'h0045);
    repeat (10) @(negedge clk);
    fault = 1'b1;
    @(negedge clk) fault = 1'b0;
    chk({go_pulse, irq, cmd_rd_data[7:0]}, 16'h01C4);
    // initialize in mid pulse drops go and the pulse
    wr(REG_IDX_CMD, 16'h0003);
    repeat (4) @(negedge clk);
    @(negedge clk) bus_init = 1'b1;
    @(negedge clk) bus_init = 1'b0;
    chk({go_pulse, cmd_rd_data[7:0]}, 16'h0080);
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge clk);
    reset = 1'b0;
    t_fcn();
    t_irq();
    t_read();
    t_space();
    t_rewind();
    t_fault();
    test_done();
  end
  initial begin
    repeat (6000) @(posedge clk);
    err_total++;
    test_done();
  end
endmodule
